// ---- hdl/flash_lock_pkg.sv ----
// constants of the lock-bit host controller: register map, flash command
// codes, status byte layout and bus cycle timing
// assumes a 20 MHz clk_i and an 8-bit flash with 20 address lines
//
// What this block does
// - poll status byte until ready flag reads one
// - clear protection bits with 60H then D0H
// - write FFH afterwards to restore array read
// - issue clear-status before retry after any error
// - after a reset abort, wait out wake time and go idle without reissuing
// - writes only while write-enable and select low
// - every altering operation needs setup then confirm
// - set bit: 60H then 01H block or F1H
package flash_lock_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int WE_LOW_NS = 100;
   localparam int ACCESS_NS = 120;
   localparam int SETTLE_NS = 50;
   localparam int RESET_LOW_NS = 100;
   localparam int RESET_WAKE_NS = 600;
   localparam logic [4:0] WE_LOW_CYC = 5'((WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [4:0] ACCESS_CYC = 5'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [4:0] SETTLE_CYC = 5'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [4:0] RST_LOW_CYC = 5'((RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [4:0] RST_WAKE_CYC = 5'((RESET_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [4:0] SYNC_CYC = 5'h02;

   // ---------------------------------------------------------------
   // flash command codes and status byte
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_SETUP = 8'h60;
   localparam logic [7:0] CMD_CLEAR_CONFIRM = 8'hd0;
   localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'h01;
   localparam logic [7:0] CMD_PERM_CONFIRM = 8'hf1;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam int READY_BIT = 7;
   localparam logic [7:0] ERR_MASK = 8'h3a;

   // ---------------------------------------------------------------
   // register map (byte offsets) and fields
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h4;
   localparam logic [3:0] REG_CTRL = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;
   localparam logic [2:0] OP_NONE = 3'h0;
   localparam logic [2:0] OP_READ_STATUS = 3'h1;
   localparam logic [2:0] OP_CLEAR_STATUS = 3'h2;
   localparam logic [2:0] OP_SET_BLOCK = 3'h3;
   localparam logic [2:0] OP_SET_PERM = 3'h4;
   localparam logic [2:0] OP_CLEAR_BITS = 3'h5;
   localparam logic [2:0] OP_READ_ARRAY = 3'h6;
   localparam logic [2:0] OP_ABORT = 3'h7;
   localparam int CTRL_WP_BIT = 0;
   localparam int CTRL_HOLD_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
endpackage

// ---- hdl/flash_cycle_if.sv ----
// one flash bus cycle request between sequencer and cycle engine
// assumes both ends on the same clock
`timescale 1ns/10ps
`default_nettype none
interface flash_cycle_if;
   logic req;
   logic wr;
   logic kill;
   logic [19:0] addr;
   logic [7:0] wdata;
   logic done;
   logic [7:0] rdata;
   modport ctrl(output req, output wr, output kill, output addr, output wdata, input done, input rdata);
   modport engine(input req, input wr, input kill, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// ---- hdl/flash_cycle.sv ----
// single write or read cycle on the flash pins
// assumes dq from the flash is asynchronous to clk_i
`timescale 1ns/10ps
`default_nettype none
module flash_cycle (
   input wire logic clk_i,
   input wire logic rst_i,
   flash_cycle_if.engine cyc,
   output logic [19:0] flash_addr_o,
   input wire logic [7:0] flash_dq_i,
   output logic [7:0] flash_dq_o,
   output logic flash_dq_oe_o,
   output logic flash_ce_n_o,
   output logic flash_we_n_o,
   output logic flash_oe_n_o
);
   typedef enum logic [2:0] {
      C_IDLE = 3'b000,
      C_SETUP = 3'b001,
      C_WE = 3'b010,
      C_HOLD = 3'b011,
      C_READ = 3'b100
   } cyc_e;

   cyc_e state;
   logic [4:0] cnt;
   logic [7:0] dq_meta;
   logic [7:0] dq_sync;

   always_ff @(posedge clk_i) begin
      dq_meta <= flash_dq_i;
      dq_sync <= dq_meta;
   end

   // ---------------------------------------------------------------
   // cycle sequencing
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || cyc.kill) begin
         state <= C_IDLE;
         cnt <= 5'h00;
         cyc.done <= 1'b0;
         flash_ce_n_o <= 1'b1;
         flash_we_n_o <= 1'b1;
         flash_oe_n_o <= 1'b1;
         flash_dq_oe_o <= 1'b0;
      end else begin
         cyc.done <= 1'b0;
         case (state)
            C_IDLE: begin
               // done high means the sequencer has not yet moved on
               if (cyc.req && !cyc.done) begin
                  flash_ce_n_o <= 1'b0;
                  if (cyc.wr) begin
                     flash_dq_oe_o <= 1'b1;
                     state <= C_SETUP;
                  end else begin
                     flash_oe_n_o <= 1'b0;
                     cnt <= flash_lock_pkg::ACCESS_CYC + flash_lock_pkg::SYNC_CYC - 5'h01;
                     state <= C_READ;
                  end
               end
            end
            C_SETUP: begin
               flash_we_n_o <= 1'b0;
               cnt <= flash_lock_pkg::WE_LOW_CYC - 5'h01;
               state <= C_WE;
            end
            C_WE: begin
               if (cnt == 5'h00) begin
                  flash_we_n_o <= 1'b1;
                  cnt <= flash_lock_pkg::SETTLE_CYC - 5'h01;
                  state <= C_HOLD;
               end else begin
                  cnt <= cnt - 5'h01;
               end
            end
            C_HOLD: begin
               if (cnt == 5'h00) begin
                  flash_ce_n_o <= 1'b1;
                  flash_dq_oe_o <= 1'b0;
                  cyc.done <= 1'b1;
                  state <= C_IDLE;
               end else begin
                  cnt <= cnt - 5'h01;
               end
            end
            C_READ: begin
               if (cnt == 5'h00) begin
                  flash_ce_n_o <= 1'b1;
                  flash_oe_n_o <= 1'b1;
                  cyc.done <= 1'b1;
                  state <= C_IDLE;
               end else begin
                  cnt <= cnt - 5'h01;
               end
            end
            default: state <= C_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flash_addr_o <= 20'h00000;
         flash_dq_o <= 8'h00;
         cyc.rdata <= 8'h00;
      end else begin
         if (state == C_IDLE && cyc.req && !cyc.done) begin
            flash_addr_o <= cyc.addr;
            flash_dq_o <= cyc.wdata;
         end
         if (state == C_READ && cnt == 5'h00) begin
            cyc.rdata <= dq_sync;
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence we_pulse_s;
      !flash_we_n_o [*2] ##1 flash_we_n_o;
   endsequence

   we_needs_ce_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !flash_we_n_o |-> !flash_ce_n_o) else $error("write enable low without chip select");
   we_pulse_len_a: assert property (@(posedge clk_i) disable iff (rst_i || cyc.kill)
      $fell(flash_we_n_o) |-> we_pulse_s) else $error("write pulse width wrong");
   oe_we_apart_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !(!flash_we_n_o && !flash_oe_n_o)) else $error("output and write enable both low");
endmodule
`default_nettype wire

// ---- hdl/flash_lock_host.sv ----
// host controller that sets and clears flash block protection bits
// assumes classic wishbone software access and a flash on plain pins
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module flash_lock_host (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [19:0] flash_addr_o,
   input wire logic [7:0] flash_dq_i,
   output logic [7:0] flash_dq_o,
   output logic flash_dq_oe_o,
   output logic flash_ce_n_o,
   output logic flash_we_n_o,
   output logic flash_oe_n_o,
   output logic reset_powerdown_n_o,
   output logic write_protect_n_o
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_SR_CMD = 4'b0001,
      ST_SR_READ = 4'b0010,
      ST_SETUP = 4'b0011,
      ST_CONFIRM = 4'b0100,
      ST_POLL = 4'b0101,
      ST_CLR = 4'b0110,
      ST_ARRAY = 4'b0111,
      ST_RST_LOW = 4'b1000,
      ST_RST_WAIT = 4'b1001
   } seq_e;

   flash_cycle_if ifc ();

   seq_e state;
   logic [4:0] cnt;
   logic [2:0] cur_op;
   logic [19:0] addr_reg;
   logic [1:0] ctrl;
   logic [7:0] status_byte;
   logic done_flag;
   logic err_flag;
   logic aborted;
   logic [7:0] last_wr;
   logic wb_take;
   logic cmd_wr;
   logic accept;
   logic abort_req;
   logic busy;
   logic ready_now;
   logic err_now;
   logic fin;
   logic in_reset;

   // ---------------------------------------------------------------
   // cycle engine
   // ---------------------------------------------------------------
   flash_cycle u_cycle (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc(ifc.engine),
      .flash_addr_o(flash_addr_o),
      .flash_dq_i(flash_dq_i),
      .flash_dq_o(flash_dq_o),
      .flash_dq_oe_o(flash_dq_oe_o),
      .flash_ce_n_o(flash_ce_n_o),
      .flash_we_n_o(flash_we_n_o),
      .flash_oe_n_o(flash_oe_n_o)
   );

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   assign wb_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign cmd_wr = wb_take && wb_we_i && wb_sel_i[0] && wb_adr_i == flash_lock_pkg::REG_CMD;
   assign abort_req = cmd_wr && wb_dat_i[2:0] == flash_lock_pkg::OP_ABORT && !in_reset;
   assign accept = cmd_wr && state == ST_IDLE && !ctrl[flash_lock_pkg::CTRL_HOLD_BIT]
      && wb_dat_i[2:0] != flash_lock_pkg::OP_NONE && wb_dat_i[2:0] != flash_lock_pkg::OP_ABORT;
   assign in_reset = state == ST_RST_LOW || state == ST_RST_WAIT;
   assign busy = state != ST_IDLE;
   assign ready_now = ifc.rdata[flash_lock_pkg::READY_BIT];
   assign err_now = err_flag || (ifc.rdata & flash_lock_pkg::ERR_MASK) != 8'h00;
   assign fin = ifc.done && (state == ST_ARRAY
      || (state == ST_CLR && cur_op == flash_lock_pkg::OP_CLEAR_STATUS)
      || (state == ST_SR_READ && ready_now && cur_op == flash_lock_pkg::OP_READ_STATUS));

   // reset pin low only in ST_RST_LOW, so no write can meet it
   assign reset_powerdown_n_o = state != ST_RST_LOW;
   assign write_protect_n_o = ctrl[flash_lock_pkg::CTRL_WP_BIT];

   assign ifc.kill = abort_req;
   assign ifc.req = state inside {ST_SR_CMD, ST_SR_READ, ST_SETUP, ST_CONFIRM, ST_POLL, ST_CLR, ST_ARRAY};
   assign ifc.wr = !(state == ST_SR_READ || state == ST_POLL);
   assign ifc.addr = state == ST_CONFIRM ? addr_reg : 20'h00000;

   always_comb begin
      case (state)
         ST_SR_CMD: ifc.wdata = flash_lock_pkg::CMD_READ_STATUS;
         ST_SETUP: ifc.wdata = flash_lock_pkg::CMD_SETUP;
         ST_CONFIRM: begin
            if (cur_op == flash_lock_pkg::OP_CLEAR_BITS) begin
               ifc.wdata = flash_lock_pkg::CMD_CLEAR_CONFIRM;
            end else if (cur_op == flash_lock_pkg::OP_SET_PERM) begin
               ifc.wdata = flash_lock_pkg::CMD_PERM_CONFIRM;
            end else begin
               ifc.wdata = flash_lock_pkg::CMD_BLOCK_CONFIRM;
            end
         end
         ST_CLR: ifc.wdata = flash_lock_pkg::CMD_CLEAR_STATUS;
         ST_ARRAY: ifc.wdata = flash_lock_pkg::CMD_READ_ARRAY;
         default: ifc.wdata = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // command sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         cnt <= 5'h00;
      end else if (abort_req) begin
         state <= ST_RST_LOW;
         cnt <= flash_lock_pkg::RST_LOW_CYC - 5'h01;
      end else begin
         case (state)
            ST_IDLE: begin
               if (ctrl[flash_lock_pkg::CTRL_HOLD_BIT]) begin
                  state <= ST_RST_LOW;
                  cnt <= flash_lock_pkg::RST_LOW_CYC - 5'h01;
               end else if (accept) begin
                  case (wb_dat_i[2:0])
                     flash_lock_pkg::OP_CLEAR_STATUS: state <= ST_CLR;
                     flash_lock_pkg::OP_READ_ARRAY: state <= ST_ARRAY;
                     default: state <= ST_SR_CMD;
                  endcase
               end
            end
            ST_SR_CMD: if (ifc.done) state <= ST_SR_READ;
            ST_SR_READ: begin
               if (ifc.done && ready_now) begin
                  state <= cur_op == flash_lock_pkg::OP_READ_STATUS ? ST_IDLE : ST_SETUP;
               end
            end
            ST_SETUP: if (ifc.done) state <= ST_CONFIRM;
            ST_CONFIRM: if (ifc.done) state <= ST_POLL;
            ST_POLL: begin
               if (ifc.done && ready_now) begin
                  state <= err_now ? ST_CLR : ST_ARRAY;
               end
            end
            ST_CLR: begin
               if (ifc.done) begin
                  state <= cur_op == flash_lock_pkg::OP_CLEAR_STATUS ? ST_IDLE : ST_ARRAY;
               end
            end
            ST_ARRAY: if (ifc.done) state <= ST_IDLE;
            ST_RST_LOW: begin
               if (cnt != 5'h00) begin
                  cnt <= cnt - 5'h01;
               end else if (!ctrl[flash_lock_pkg::CTRL_HOLD_BIT]) begin
                  state <= ST_RST_WAIT;
                  cnt <= flash_lock_pkg::RST_WAKE_CYC - 5'h01;
               end
            end
            ST_RST_WAIT: begin
               if (cnt != 5'h00) begin
                  cnt <= cnt - 5'h01;
               end else begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // result flags and status mirror
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_flag <= 1'b0;
         err_flag <= 1'b0;
         aborted <= 1'b0;
      end else if (accept) begin
         done_flag <= 1'b0;
         err_flag <= 1'b0;
         aborted <= 1'b0;
      end else begin
         if (fin) done_flag <= 1'b1;
         if (abort_req && busy) aborted <= 1'b1;
         if (ifc.done && !ifc.wr && ifc.rdata[flash_lock_pkg::READY_BIT]
            && (ifc.rdata & flash_lock_pkg::ERR_MASK) != 8'h00) begin
            err_flag <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_byte <= 8'h00;
      end else if (state == ST_RST_LOW) begin
         status_byte <= 8'h00;
      end else if (ifc.done && !ifc.wr) begin
         status_byte <= ifc.rdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_wr <= 8'h00;
      end else if (ifc.done && ifc.wr) begin
         last_wr <= ifc.wdata;
      end
   end

   // ---------------------------------------------------------------
   // wishbone registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_take;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_op <= flash_lock_pkg::OP_NONE;
         addr_reg <= flash_lock_pkg::ADDR_RESET;
         ctrl <= flash_lock_pkg::CTRL_RESET;
      end else begin
         if (accept) cur_op <= wb_dat_i[2:0];
         if (wb_take && wb_we_i && wb_adr_i == flash_lock_pkg::REG_ADDR) begin
            if (wb_sel_i[0]) addr_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) addr_reg[15:8] <= wb_dat_i[15:8];
            if (wb_sel_i[2]) addr_reg[19:16] <= wb_dat_i[19:16];
         end
         if (wb_take && wb_we_i && wb_sel_i[0] && wb_adr_i == flash_lock_pkg::REG_CTRL) begin
            ctrl <= wb_dat_i[1:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h00000000;
      end else if (wb_take && !wb_we_i) begin
         case (wb_adr_i)
            flash_lock_pkg::REG_CMD: wb_dat_o <= {29'h0, cur_op};
            flash_lock_pkg::REG_ADDR: wb_dat_o <= {12'h000, addr_reg};
            flash_lock_pkg::REG_CTRL: wb_dat_o <= {30'h0, ctrl};
            flash_lock_pkg::REG_STATUS: wb_dat_o <= {20'h0, aborted, err_flag, done_flag, busy, status_byte};
            default: wb_dat_o <= 32'h00000000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence confirm_s;
      state == ST_CONFIRM && ifc.req;
   endsequence

   sequence rst_low_s;
      !reset_powerdown_n_o [*2] ##1 1'b1;
   endsequence

   setup_first_a: assert property (confirm_s |-> last_wr == flash_lock_pkg::CMD_SETUP)
      else $error("confirm write without setup before it");
   clear_code_a: assert property (confirm_s and cur_op == flash_lock_pkg::OP_CLEAR_BITS
      |-> ifc.wdata == flash_lock_pkg::CMD_CLEAR_CONFIRM) else $error("clear confirm code wrong");
   perm_code_a: assert property (confirm_s and cur_op == flash_lock_pkg::OP_SET_PERM
      |-> ifc.wdata == flash_lock_pkg::CMD_PERM_CONFIRM && ifc.addr == addr_reg)
      else $error("permanent bit confirm wrong");
   poll_wait_a: assert property (state == ST_POLL && ifc.done && !ready_now |=> state == ST_POLL)
      else $error("left polling while device busy");
   ready_gate_a: assert property (state == ST_SR_READ && ifc.done && !ready_now
      |=> state == ST_SR_READ) else $error("started command while device busy");
   array_back_a: assert property (state == ST_IDLE && $past(state) == ST_ARRAY
      |-> last_wr == flash_lock_pkg::CMD_READ_ARRAY) else $error("no array read restore at end");
   err_clear_a: assert property (state == ST_ARRAY && ifc.req && err_flag
      && cur_op != flash_lock_pkg::OP_READ_ARRAY |-> last_wr == flash_lock_pkg::CMD_CLEAR_STATUS)
      else $error("error not cleared");
   rst_pulse_a: assert property ($fell(reset_powerdown_n_o) |-> rst_low_s)
      else $error("reset pulse too short");
   abort_mark_a: assert property (abort_req && busy |=> aborted && state == ST_RST_LOW)
      else $error("abort not recorded");
   rst_no_write_a: assert property (!reset_powerdown_n_o |-> flash_we_n_o && flash_ce_n_o)
      else $error("write attempted during reset");
endmodule
`default_nettype wire

// ---- testbench/flash_lock_model.sv ----
// behavioural flash device: status byte, two-step commands, lock bits
// assumes the host drives pins straight from its registers
`timescale 1ns/10ps
`default_nettype none
module flash_lock_model (
   input wire logic ce_n_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic rp_n_i,
   input wire logic perm_i,
   input wire logic supply_low_i,
   input wire logic [7:0] dq_i,
   output logic [7:0] dq_o
);
   logic [7:0] sr = 8'h80;
   logic setup = 1'b0;
   // deselected: inverse of the byte, never a stale copy
   assign dq_o = (!ce_n_i && !oe_n_i && rp_n_i) ? sr : ~sr;
   always @(posedge we_n_i or negedge rp_n_i) begin
      if (!rp_n_i) begin
         sr = 8'h80;
         setup = 1'b0;
      end else if (!ce_n_i) begin
         if (setup && dq_i inside {8'h01, 8'hf1, 8'hd0}) begin
            sr[7] = 1'b0;
            if (perm_i) sr[1] = 1'b1;
            // low supply: supply flag plus the flag of the attempted operation
            if (supply_low_i) sr[5:3] = (dq_i == 8'hd0) ? 3'b101 : 3'b011;
            sr[7] <= #1000 1'b1;
         end else if (setup) sr[5:4] = 2'b11;
         else if (dq_i == 8'h50) sr[5:1] = 5'h00;
         setup = (dq_i == 8'h60) && !setup;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/lock_bit_command_status_bench.sv ----
// self-checking bench for the lock-bit host controller
// assumes the behavioural flash model on the far side
`timescale 1ns/10ps
`default_nettype none
module lock_bit_command_status_bench;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, perm;
   logic [3:0] wb_adr_i;
   logic [3:0] wb_sel_i = 4'hf;
   logic supply_low = 1'b0;
   logic [31:0] wb_dat_i, wb_dat_o, d;
   logic wb_ack_o, flash_dq_oe_o, flash_ce_n_o, flash_we_n_o, flash_oe_n_o;
   logic reset_powerdown_n_o, write_protect_n_o, rp_seen;
   logic [19:0] flash_addr_o, cfa;
   logic [7:0] flash_dq_i, flash_dq_o;
   logic [7:0] wq[$];
   int fail_count = 0;
   int num_checks = 0;
   flash_lock_host flash_lock_host_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .flash_addr_o, .flash_dq_i, .flash_dq_o, .flash_dq_oe_o,
      .flash_ce_n_o, .flash_we_n_o, .flash_oe_n_o, .reset_powerdown_n_o, .write_protect_n_o);
   flash_lock_model flash_lock_model_i (.ce_n_i(flash_ce_n_o), .we_n_i(flash_we_n_o), .oe_n_i(flash_oe_n_o),
      .rp_n_i(reset_powerdown_n_o), .perm_i(perm), .supply_low_i(supply_low), .dq_i(flash_dq_o),
      .dq_o(flash_dq_i));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   always @(posedge flash_we_n_o) if (!flash_ce_n_o) begin
      wq.push_back(flash_dq_o);
      if (flash_dq_o inside {8'h01, 8'hf1}) cfa = flash_addr_o;
   end
   always @(negedge reset_powerdown_n_o) rp_seen = 1'b1;
   // write strobe only with data driven, select low and outputs off
   always @(negedge flash_we_n_o) chk({flash_dq_oe_o, flash_oe_n_o, flash_ce_n_o}, 3'b110);
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v, output logic [31:0] q);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, v};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask
   function automatic logic [39:0] packq();
      logic [39:0] v;
      v = '0;
      foreach (wq[i]) v = {v[31:0], wq[i]};
      return v;
   endfunction
   task automatic run_op(input logic [2:0] op, output logic [31:0] st);
      int n;
      n = 0;
      wq.delete();
      wb(1'b1, flash_lock_pkg::REG_CMD, {29'h0, op}, st);
      do begin
         wb(1'b0, flash_lock_pkg::REG_STATUS, 32'h0, st);
         n++;
      end while (st[8] !== 1'b0 && n < 400);
      chk({39'h0, st[8]}, 40'h0);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   initial begin
      #3000000;
      fail_count++;
      tally_and_finish();
   end
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, perm, rp_seen} = {1'b1, 39'h0, 2'b00};
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, flash_lock_pkg::REG_CTRL, 32'h0, d);
      chk(d, 32'h1);
      chk({write_protect_n_o, reset_powerdown_n_o}, 2'b11);
      wb(1'b0, 4'h2, 32'h0, d);
      chk(d, 32'h0);
      wb(1'b1, flash_lock_pkg::REG_ADDR, 32'h000abcde, d);
      run_op(flash_lock_pkg::OP_SET_BLOCK, d);
      chk(d[11:0], 12'h280);
      chk(packq(), 40'h00706001ff);
      chk(cfa, 20'habcde);
      perm = 1'b1;
      run_op(flash_lock_pkg::OP_CLEAR_BITS, d);
      chk(d[11:0], 12'h682);
      chk(packq(), 40'h7060d050ff);
      run_op(flash_lock_pkg::OP_READ_STATUS, d);
      chk({d[7:0], packq()}, {8'h80, 40'h70});
      perm = 1'b0;
      run_op(flash_lock_pkg::OP_SET_PERM, d);
      chk({d[11:0], packq()}, {12'h280, 40'h7060f1ff});
      run_op(flash_lock_pkg::OP_CLEAR_STATUS, d);
      chk(packq(), 40'h50);
      run_op(flash_lock_pkg::OP_READ_ARRAY, d);
      chk(packq(), 40'hff);
      supply_low = 1'b1;
      run_op(flash_lock_pkg::OP_SET_BLOCK, d);
      chk({d[11:0], packq()}, {12'h698, 40'h70600150ff});
      run_op(flash_lock_pkg::OP_CLEAR_BITS, d);
      chk({d[11:0], packq()}, {12'h6a8, 40'h7060d050ff});
      supply_low = 1'b0;
      wb(1'b1, flash_lock_pkg::REG_CMD, 32'h3, d);
      run_op(flash_lock_pkg::OP_ABORT, d);
      chk({d[11], d[7:0], rp_seen}, {1'b1, 8'h00, 1'b1});
      wb(1'b1, flash_lock_pkg::REG_CTRL, 32'h2, d);
      repeat (3) @(posedge clk_i);
      chk({write_protect_n_o, reset_powerdown_n_o}, 2'b00);
      wb(1'b1, flash_lock_pkg::REG_CTRL, 32'h1, d);
      // no-op command is ignored; polling waits out the wake time
      run_op(flash_lock_pkg::OP_NONE, d);
      chk({d[11], d[7:0]}, {1'b1, 8'h00});
      run_op(flash_lock_pkg::OP_SET_BLOCK, d);
      chk({d[11:0], packq()}, {12'h280, 40'h706001ff});
      tally_and_finish();
   end
endmodule
`default_nettype wire
